// >>> logic/mrs_pkg.sv
package mrs_pkg;
    // Identification page offset
    localparam logic [7:0] MRS_TAGS_OFFSET     = 8'h0D;
    // Diagnostic page offset and bit of the software select
    localparam logic [7:0] MRS_SOFT_SEL_OFFSET = 8'h6E;
    localparam int         MRS_SOFT_SEL_BIT    = 3;
    // Compliance tag layout
    localparam int         MRS_TAG_FC_BIT      = 0;
    localparam logic [7:0] MRS_TAGS_RESERVED   = 8'hFE;
    localparam logic [7:0] MRS_TAGS_FC         = 8'h01;
    localparam logic [7:0] MRS_TAGS_RESET      = 8'h00;
    localparam logic [7:0] MRS_SOFT_RESET      = 8'h00;
    // Synchroniser depth
    localparam int         MRS_SYNC_STAGES     = 3;
    // Receive settings
    typedef enum logic [0:0] {
        MRS_RX_LOW  = 1'b0,
        MRS_RX_HIGH = 1'b1
    } mrs_rx_e;
endpackage

// >>> logic/mrs_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser, change taken once stages two and three agree
module mrs_pin_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Pin and result
    input  wire logic pin_in,
    output logic      level_out
);
    import mrs_pkg::*;

    logic [2:0] stage_reg;

    // Shift the pin through three flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage_reg <= 3'h0;
        end else begin
            stage_reg <= {stage_reg[1:0], pin_in};
        end
    end

    // Accept new level only when stages agree
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            level_out <= 1'b0;
        end else if (stage_reg[1] == stage_reg[2]) begin
            level_out <= stage_reg[2];
        end
    end
endmodule
`default_nettype wire

// >>> logic/mrs_rate_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_rate_ctrl #(
    parameter bit FC_GROUPING   = 1'b1,
    parameter bit LOW_ALSO_MID  = 1'b0,
    parameter bit SOFT_SELECT   = 1'b1
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // Select pin, low when open
    input  wire logic       speed_choice_pin,
    // Register access port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       diag_page,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Receiver and transmitter settings
    output logic            rx_rate_high,
    output logic            rx_mid_capable,
    output logic            tx_rate_fixed,
    output logic            legacy_mode
);
    import mrs_pkg::*;

    logic       pin_level;
    logic [7:0] soft_reg;
    logic [7:0] tags_reg;
    logic       eff_sel;
    mrs_rx_e    rx_next;

    // Pin synchroniser
    mrs_pin_sync u_sync (
        .clock     (clock),
        .nrst      (nrst),
        .pin_in    (speed_choice_pin),
        .level_out (pin_level)
    );

    // Tag byte, captured after reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tags_reg <= MRS_TAGS_RESET;
        end else begin
            tags_reg <= (FC_GROUPING ? MRS_TAGS_FC : 8'h00) & ~MRS_TAGS_RESERVED;
        end
    end

    // Software select byte in diagnostic page
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            soft_reg <= MRS_SOFT_RESET;
        end else if (SOFT_SELECT && reg_wr && diag_page && reg_addr == MRS_SOFT_SEL_OFFSET) begin
            soft_reg <= reg_wdata;
        end
    end

    // Effective select, pin OR software bit
    assign eff_sel = pin_level | (SOFT_SELECT & soft_reg[MRS_SOFT_SEL_BIT]);
    assign rx_next = eff_sel ? MRS_RX_HIGH : MRS_RX_LOW;

    // Receiver setting; transmitter never steered
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_rate_high   <= 1'b0;
            rx_mid_capable <= 1'b0;
            tx_rate_fixed  <= 1'b1;
            legacy_mode    <= 1'b1;
        end else begin
            rx_rate_high   <= rx_next;
            rx_mid_capable <= rx_next == MRS_RX_HIGH || LOW_ALSO_MID;
            tx_rate_fixed  <= 1'b1;
            legacy_mode    <= tags_reg == 8'h00;
        end
    end

    // Read mux
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (!diag_page && reg_addr == MRS_TAGS_OFFSET) begin
            reg_rdata <= tags_reg;
        end else if (diag_page && reg_addr == MRS_SOFT_SEL_OFFSET) begin
            reg_rdata <= soft_reg;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Checks
    chk_sel_or: assert property (@(posedge clock) disable iff (!nrst)
        $past(eff_sel) |-> rx_rate_high) else $error("high select not applied");
    chk_low_rate: assert property (@(posedge clock) disable iff (!nrst)
        !$past(eff_sel) |-> !rx_rate_high) else $error("low select not applied");
    chk_tags_rsvd: assert property (@(posedge clock) disable iff (!nrst)
        (tags_reg & MRS_TAGS_RESERVED) == 8'h00) else $error("reserved tag set");
    chk_tx_fixed: assert property (@(posedge clock) disable iff (!nrst)
        tx_rate_fixed) else $error("transmitter steered");
    chk_legacy: assert property (@(posedge clock) disable iff (!nrst)
        $past(tags_reg) == 8'h00 |-> legacy_mode) else $error("legacy flag wrong");
    chk_tag_read: assert property (@(posedge clock) disable iff (!nrst)
        (!diag_page && reg_addr == MRS_TAGS_OFFSET) |=> reg_rdata == $past(tags_reg))
        else $error("tag byte read wrong");
    chk_pin_path: assert property (@(posedge clock) disable iff (!nrst)
        speed_choice_pin [*5] |=> rx_rate_high) else $error("pin high not reached");
endmodule
`default_nettype wire

// >>> tb/mrs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: drives the select pin to follow its wanted receive rate
module mrs_host_model (
    // Clock and request
    input  wire logic clock,
    input  wire logic want_high,
    // Select pin
    output logic      speed_choice_pin
);
    // Pin low at start, then changed only off the sampling edge
    initial speed_choice_pin = 1'b0;
    always @(negedge clock) speed_choice_pin <= want_high;
endmodule
`default_nettype wire

// >>> tb/module_rate_select_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module module_rate_select_control_tb_top;
    import mrs_pkg::*;
    logic       clock = 0, nrst = 0, want = 0, wr = 0, page = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic       pin, rx_hi, rx_mid, tx_fix, legacy;
    int         errors = 0, n_compared = 0;
    initial forever #4 clock = ~clock;
    mrs_host_model host (.clock(clock), .want_high(want), .speed_choice_pin(pin));
    mrs_rate_ctrl DUT (.clock(clock), .nrst(nrst), .speed_choice_pin(pin),
        .reg_addr(addr), .reg_wr(wr), .diag_page(page), .reg_wdata(wdata),
        .reg_rdata(rdata), .rx_rate_high(rx_hi), .rx_mid_capable(rx_mid),
        .tx_rate_fixed(tx_fix), .legacy_mode(legacy));
    // Compare and count
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read one byte, data valid one cycle after the address
    task automatic rd(logic [7:0] a, logic p, logic [7:0] exp, string what);
        @(negedge clock);
        addr = a;
        page = p;
        @(negedge clock);
        check(what, exp, rdata);
    endtask
    // One-cycle write strobe
    task automatic wrt(logic [7:0] a, logic p, logic [7:0] d);
        @(negedge clock);
        addr = a;
        page = p;
        wdata = d;
        wr = 1;
        @(negedge clock);
        wr = 0;
    endtask
    // Bounded wait for the receive setting
    task automatic wait_rx(logic exp, string what);
        for (int i = 0; i < 8 && rx_hi !== exp; i++) @(negedge clock);
        check(what, exp, rx_hi);
    endtask
    task automatic test_reset();
        check("tx_rst", 1, tx_fix);
        check("legacy_rst", 1, legacy);
        repeat (2) @(negedge clock);
        nrst = 1;
        repeat (3) @(negedge clock);
        check("legacy", 0, legacy);
        check("rx_low", 0, rx_hi);
    endtask
    task automatic test_tags();
        rd(MRS_TAGS_OFFSET, 0, MRS_TAGS_FC, "tags");
        wrt(MRS_TAGS_OFFSET, 0, 8'hFF);
        rd(MRS_TAGS_OFFSET, 0, MRS_TAGS_FC, "tags_ro");
        rd(8'h20, 0, 8'h00, "unmapped");
        wrt(MRS_SOFT_SEL_OFFSET, 0, 8'h08);
        rd(MRS_SOFT_SEL_OFFSET, 1, 8'h00, "soft_wrong_page");
        check("rx_wrong_page", 0, rx_hi);
    endtask
    task automatic test_soft();
        wrt(MRS_SOFT_SEL_OFFSET, 1, 8'h08);
        check("rx_early", 0, rx_hi);
        @(negedge clock);
        check("rx_soft", 1, rx_hi);
        check("mid_hi", 1, rx_mid);
        rd(MRS_SOFT_SEL_OFFSET, 1, 8'h08, "soft_rd");
        wrt(MRS_SOFT_SEL_OFFSET, 1, 8'h00);
        wait_rx(0, "rx_soft_off");
        check("mid_lo", 0, rx_mid);
    endtask
    task automatic test_pin();
        want = 1;
        wait_rx(1, "rx_pin");
        check("tx_pin", 1, tx_fix);
        wrt(MRS_SOFT_SEL_OFFSET, 1, 8'h08);
        want = 0;
        repeat (8) @(negedge clock);
        check("rx_or", 1, rx_hi);
        wrt(MRS_SOFT_SEL_OFFSET, 1, 8'h00);
        wait_rx(0, "rx_both_off");
    endtask
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial begin
        @(negedge clock);
        test_reset();
        test_tags();
        test_soft();
        test_pin();
        give_verdict();
    end
endmodule
`default_nettype wire
